// file: inc/exec_pkg.sv
// Function
// - Increment to accumulator, skip on zero sum
// - Taken skip adds dummy cycle, no flags
// - Bit-set skip when selected bit is one
// - Register subtract into accumulator, four flags
// - Carry cleared on borrow, set otherwise
// - Memory subtract writes operand, four flags
// - Immediate subtract into accumulator, four flags
// - Memory nibble exchange in place, no flags
// - Nibble exchange into accumulator, no flags
// - Skip when whole operand is zero
// - Copy operand to accumulator, skip if zero
// - Bit-clear skip when selected bit is zero
// - Table read via high and low pointers
// - Last page table read via low pointer
// - Register xor into accumulator, zero flag only
// - Memory xor into operand, zero flag only
// - Immediate xor into accumulator
package exec_pkg;

  // ==========================================
  // Operation codes
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_INC_ACC_SKIP = 5'h01,
    OP_SKIP_BIT_SET = 5'h02,
    OP_SUB_ACC = 5'h03,
    OP_SUB_MEM = 5'h04,
    OP_SUB_IMM = 5'h05,
    OP_SWAP_MEM = 5'h06,
    OP_SWAP_ACC = 5'h07,
    OP_SKIP_ZERO = 5'h08,
    OP_COPY_SKIP = 5'h09,
    OP_SKIP_BIT_CLR = 5'h0A,
    OP_TABLE_READ = 5'h0B,
    OP_LAST_PAGE_READ = 5'h0C,
    OP_XOR_ACC = 5'h0D,
    OP_XOR_MEM = 5'h0E,
    OP_XOR_IMM = 5'h0F
  } op_t;

  // ==========================================
  // Cycle states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_TABLE = 2'b01,
    ST_DUMMY = 2'b10
  } state_t;

  // ==========================================
  // Widths, reset values, flag positions
  localparam int DATA_W = 8;
  localparam int PROG_AW = 12;
  localparam int PROG_DW = 16;
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam logic [7:0] LAST_PAGE = 8'hFF;

endpackage : exec_pkg

// file: hw/prog_rom.sv
module prog_rom #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  // Clock
  input wire logic clock_i,
  // Load port
  input wire logic load_en_i,
  input wire logic [AW-1:0] load_addr_i,
  input wire logic [DW-1:0] load_data_i,
  // Read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Registered read; table fetch costs a cycle
  always_ff @(posedge clock_i)
  begin
    if (load_en_i)
    begin
      mem[load_addr_i] <= load_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : prog_rom

// file: hw/exec_unit.sv
module exec_unit #(
  parameter int PROG_AW = exec_pkg::PROG_AW
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Instruction issue
  input wire logic issue_i,
  input wire logic [4:0] op_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_sel_i,
  // Table pointers
  input wire logic [7:0] program_pointer_low_i,
  input wire logic [7:0] program_pointer_high_i,
  // Program memory load
  input wire logic rom_load_i,
  input wire logic [PROG_AW-1:0] rom_addr_i,
  input wire logic [15:0] rom_data_i,
  // Results
  output logic [7:0] acc_o,
  output logic [3:0] flags_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] program_word_high_latch_o,
  output logic busy_o,
  output logic skip_o,
  output logic done_o
);

  typedef exec_pkg::op_t op_t;
  typedef exec_pkg::state_t state_t;

  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[exec_pkg::NIB_HI-1:exec_pkg::NIB_LO], v[7:exec_pkg::NIB_HI]};
  endfunction : nib_swap

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  // ==========================================
  // Decode
  wire op_t op = op_t'(op_i);
  wire state_t st_w;
  wire accept = issue_i && !busy_o;
  wire is_sub = (op == exec_pkg::OP_SUB_ACC) || (op == exec_pkg::OP_SUB_MEM) || (op == exec_pkg::OP_SUB_IMM);
  wire is_xor = (op == exec_pkg::OP_XOR_ACC) || (op == exec_pkg::OP_XOR_MEM) || (op == exec_pkg::OP_XOR_IMM);
  wire is_table = (op == exec_pkg::OP_TABLE_READ) || (op == exec_pkg::OP_LAST_PAGE_READ);
  wire is_inc = (op == exec_pkg::OP_INC_ACC_SKIP);
  wire is_bit_set = (op == exec_pkg::OP_SKIP_BIT_SET);
  wire is_bit_clr = (op == exec_pkg::OP_SKIP_BIT_CLR);
  wire is_zero_test = (op == exec_pkg::OP_SKIP_ZERO);
  wire is_copy = (op == exec_pkg::OP_COPY_SKIP);
  wire is_skip_op = is_inc || is_bit_set || is_bit_clr || is_zero_test || is_copy;
  wire is_imm = (op == exec_pkg::OP_SUB_IMM) || (op == exec_pkg::OP_XOR_IMM);
  // Immediate forms reuse the operand datapath
  wire [7:0] rhs = is_imm ? imm_i : operand_i;

  // ==========================================
  // Arithmetic
  wire [8:0] diff = {1'b0, acc_o} - {1'b0, rhs};
  wire [4:0] diff_lo = {1'b0, acc_o[3:0]} - {1'b0, rhs[3:0]};
  wire [7:0] sum_inc = operand_i + 8'h01;
  wire [7:0] xor_res = acc_o ^ rhs;
  wire sub_ov = (acc_o[7] != rhs[7]) && (diff[7] != acc_o[7]);
  wire [3:0] sub_flags = {sub_ov, is_zero(diff[7:0]), ~diff_lo[4], ~diff[8]};
  wire bit_val = operand_i[bit_sel_i];

  // Skip decision per instruction
  wire skip_inc = is_inc && is_zero(sum_inc);
  wire skip_bit_set = is_bit_set && bit_val;
  wire skip_bit_clr = is_bit_clr && !bit_val;
  wire skip_zero = is_zero_test && is_zero(operand_i);
  wire skip_copy = is_copy && is_zero(operand_i);
  wire skip_cond = skip_inc || skip_bit_set || skip_bit_clr || skip_zero || skip_copy;

  // ==========================================
  // Table address
  wire [PROG_AW-1:0] full_addr = PROG_AW'({program_pointer_high_i, program_pointer_low_i});
  wire [PROG_AW-1:0] last_addr = PROG_AW'({exec_pkg::LAST_PAGE, program_pointer_low_i});
  wire [PROG_AW-1:0] tab_addr = (op == exec_pkg::OP_LAST_PAGE_READ) ? last_addr : full_addr;
  logic [15:0] rom_q;

  prog_rom #(.AW(PROG_AW), .DW(16)) u_rom (
    .clock_i(clock_i),
    .load_en_i(rom_load_i),
    .load_addr_i(rom_addr_i),
    .load_data_i(rom_data_i),
    .rd_addr_i(tab_addr),
    .rd_data_o(rom_q)
  );

  // ==========================================
  // Next values
  state_t st_r;
  state_t st_nxt;
  logic [7:0] acc_nxt;
  logic [3:0] flags_nxt;
  logic mem_we_nxt;
  logic [7:0] mem_wdata_nxt;

  always_comb
  begin
    acc_nxt = acc_o;
    flags_nxt = flags_o;
    mem_we_nxt = 1'b0;
    mem_wdata_nxt = mem_wdata_o;
    if (accept)
    begin
      unique case (op)
        exec_pkg::OP_INC_ACC_SKIP: acc_nxt = sum_inc;
        exec_pkg::OP_SUB_ACC, exec_pkg::OP_SUB_IMM:
        begin
          acc_nxt = diff[7:0];
          flags_nxt = sub_flags;
        end
        exec_pkg::OP_SUB_MEM:
        begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = diff[7:0];
          flags_nxt = sub_flags;
        end
        exec_pkg::OP_SWAP_MEM:
        begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = nib_swap(operand_i);
        end
        exec_pkg::OP_SWAP_ACC: acc_nxt = nib_swap(operand_i);
        exec_pkg::OP_COPY_SKIP: acc_nxt = operand_i;
        exec_pkg::OP_XOR_ACC, exec_pkg::OP_XOR_IMM:
        begin
          acc_nxt = xor_res;
          flags_nxt[exec_pkg::FLAG_Z] = is_zero(xor_res);
        end
        exec_pkg::OP_XOR_MEM:
        begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = xor_res;
          flags_nxt[exec_pkg::FLAG_Z] = is_zero(xor_res);
        end
        default:
        begin
          acc_nxt = acc_o;
        end
      endcase
    end
    else if (st_r == exec_pkg::ST_TABLE)
    begin
      mem_we_nxt = 1'b1;
      mem_wdata_nxt = rom_q[7:0];
    end
  end

  // Skip adds one dummy cycle; a false skip finishes at once
  always_comb
  begin
    st_nxt = exec_pkg::ST_RUN;
    if (accept && skip_cond)
    begin
      st_nxt = exec_pkg::ST_DUMMY;
    end
    else if (accept && is_table)
    begin
      st_nxt = exec_pkg::ST_TABLE;
    end
  end

  assign st_w = st_nxt;

  // Status next values
  wire table_step = (st_r == exec_pkg::ST_TABLE);
  wire busy_nxt = (st_w != exec_pkg::ST_RUN);
  wire skip_nxt = accept && skip_cond;
  wire done_nxt = (accept && !is_table && !skip_cond) || (st_r != exec_pkg::ST_RUN);
  wire [7:0] latch_nxt = table_step ? rom_q[15:8] : program_word_high_latch_o;

  // ==========================================
  // State
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= exec_pkg::ST_RUN;
      busy_o <= 1'b0;
    end
    else
    begin
      st_r <= st_w;
      busy_o <= busy_nxt;
    end
  end

  // Accumulator and flags
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_o <= exec_pkg::ACC_RST;
      flags_o <= exec_pkg::FLAG_RST;
    end
    else
    begin
      acc_o <= acc_nxt;
      flags_o <= flags_nxt;
    end
  end

  // Operand write-back; the caller owns the data memory
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mem_we_o <= 1'b0;
      mem_wdata_o <= 8'h00;
    end
    else
    begin
      mem_we_o <= mem_we_nxt;
      mem_wdata_o <= mem_wdata_nxt;
    end
  end

  // High byte holds until the next table read
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      program_word_high_latch_o <= exec_pkg::LATCH_RST;
    end
    else
    begin
      program_word_high_latch_o <= latch_nxt;
    end
  end

  // One-cycle pulses
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      skip_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      skip_o <= skip_nxt;
      done_o <= done_nxt;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  skip_two_cycles_a: assert property (accept && skip_cond |=> busy_o ##1 !busy_o && done_o)
    else $error("skip did not take two cycles");
  skip_no_flags_a: assert property (accept && (op == exec_pkg::OP_SKIP_ZERO) |=> $stable(flags_o))
    else $error("skip changed flags");
  inc_acc_a: assert property (accept && (op == exec_pkg::OP_INC_ACC_SKIP) |=> acc_o == $past(operand_i) + 8'h01)
    else $error("increment result wrong");
  bit_set_a: assert property (accept && (op == exec_pkg::OP_SKIP_BIT_SET) && bit_val |=> skip_o)
    else $error("bit set skip missed");
  bit_clr_a: assert property (accept && (op == exec_pkg::OP_SKIP_BIT_CLR) && bit_val |=> !skip_o)
    else $error("bit clear skip wrong");
  zero_skip_a: assert property (accept && (op == exec_pkg::OP_SKIP_ZERO) |=> skip_o == ($past(operand_i) == 8'h00))
    else $error("zero skip wrong");
  copy_skip_a: assert property (accept && (op == exec_pkg::OP_COPY_SKIP) |=> acc_o == $past(operand_i))
    else $error("copy wrong");
  sub_carry_a: assert property (accept && is_sub |=> flags_o[exec_pkg::FLAG_C] == ($past(acc_o) >= $past(rhs)))
    else $error("borrow carry wrong");
  sub_acc_a: assert property (accept && (op == exec_pkg::OP_SUB_ACC) |=> acc_o == 8'($past(acc_o) - $past(operand_i)))
    else $error("subtract result wrong");
  sub_mem_a: assert property (accept && (op == exec_pkg::OP_SUB_MEM) |=> mem_we_o && $stable(acc_o))
    else $error("memory subtract wrong");
  sub_imm_a: assert property (accept && (op == exec_pkg::OP_SUB_IMM) |=> acc_o == 8'($past(acc_o) - $past(imm_i)))
    else $error("immediate subtract wrong");
  swap_mem_a: assert property (accept && (op == exec_pkg::OP_SWAP_MEM) |=> mem_we_o && $stable(flags_o))
    else $error("memory swap wrong");
  swap_acc_a: assert property (accept && (op == exec_pkg::OP_SWAP_ACC) |=> acc_o == nib_swap($past(operand_i)))
    else $error("accumulator swap wrong");
  table_write_a: assert property (accept && is_table |=> busy_o ##1 mem_we_o && done_o)
    else $error("table read timing wrong");
  xor_zero_a: assert property (accept && is_xor |=>
    {flags_o[exec_pkg::FLAG_OV], flags_o[1:0]} == {$past(flags_o[exec_pkg::FLAG_OV]), $past(flags_o[1:0])})
    else $error("xor touched other flags");
  no_skip_one_a: assert property (accept && !skip_cond && !is_table |=> done_o && !busy_o)
    else $error("plain cycle took too long");

  skip_taken_c: cover property (accept && skip_cond);
  sub_borrow_c: cover property (accept && is_sub && diff[8]);
  table_read_c: cover property (accept && (op == exec_pkg::OP_LAST_PAGE_READ));
  skip_false_c: cover property (accept && is_skip_op && !skip_cond);
  refused_issue_c: cover property (issue_i && busy_o);

  // ==========================================
  // Checks per instruction
  inc_skip_a: assert property (accept && is_inc |=> skip_o == ($past(operand_i) == 8'hFF))
    else $error("increment skip wrong");
  inc_keep_mem_a: assert property (accept && is_inc |=> !mem_we_o)
    else $error("increment wrote memory");
  skip_flags_a: assert property (accept && is_skip_op |=> $stable(flags_o))
    else $error("skip instruction changed flags");
  skip_pulse_a: assert property (skip_o |=> !skip_o)
    else $error("skip pulse too long");
  busy_refuse_a: assert property (issue_i && busy_o |=> $stable(acc_o) && $stable(flags_o) && !skip_o)
    else $error("instruction taken while busy");
  bit_set_off_a: assert property (accept && is_bit_set && !bit_val |=> !skip_o)
    else $error("bit set skip taken on zero");
  bit_clr_skip_a: assert property (accept && is_bit_clr && !bit_val |=> skip_o)
    else $error("bit clear skip missed");
  copy_zero_a: assert property (accept && is_copy |=> skip_o == ($past(operand_i) == 8'h00))
    else $error("copy skip wrong");
  plain_no_skip_a: assert property (accept && is_skip_op && !skip_cond |=> !skip_o && done_o && !busy_o)
    else $error("false skip took too long");
  sub_zero_a: assert property (accept && is_sub |=>
    flags_o[exec_pkg::FLAG_Z] == ($past(acc_o) == $past(rhs)))
    else $error("subtract zero flag wrong");
  sub_aux_a: assert property (accept && is_sub |=>
    flags_o[exec_pkg::FLAG_AC] == ($past(acc_o[3:0]) >= $past(rhs[3:0])))
    else $error("subtract half borrow wrong");
  sub_mem_data_a: assert property (accept && (op == exec_pkg::OP_SUB_MEM) |=>
    mem_wdata_o == 8'($past(acc_o) - $past(operand_i)))
    else $error("memory subtract data wrong");
  swap_mem_data_a: assert property (accept && (op == exec_pkg::OP_SWAP_MEM) |=>
    mem_wdata_o == {$past(operand_i[3:0]), $past(operand_i[7:4])})
    else $error("memory swap data wrong");
  swap_acc_keep_a: assert property (accept && (op == exec_pkg::OP_SWAP_ACC) |=>
    !mem_we_o && $stable(flags_o))
    else $error("accumulator swap touched memory or flags");
  xor_acc_a: assert property (accept && (op == exec_pkg::OP_XOR_ACC) |=>
    acc_o == ($past(acc_o) ^ $past(operand_i)))
    else $error("xor result wrong");
  xor_mem_data_a: assert property (accept && (op == exec_pkg::OP_XOR_MEM) |=>
    mem_wdata_o == ($past(acc_o) ^ $past(operand_i)) && $stable(acc_o))
    else $error("memory xor data wrong");
  xor_imm_a: assert property (accept && (op == exec_pkg::OP_XOR_IMM) |=>
    acc_o == ($past(acc_o) ^ $past(imm_i)))
    else $error("immediate xor result wrong");
  xor_flag_z_a: assert property (accept && is_xor |=>
    flags_o[exec_pkg::FLAG_Z] == ($past(acc_o) == $past(rhs)))
    else $error("xor zero flag wrong");
  table_addr_a: assert property (accept && (op == exec_pkg::OP_TABLE_READ) |->
    tab_addr == {program_pointer_high_i[PROG_AW-9:0], program_pointer_low_i})
    else $error("table address wrong");
  last_page_addr_a: assert property (accept && (op == exec_pkg::OP_LAST_PAGE_READ) |->
    tab_addr == {{(PROG_AW - 8){1'b1}}, program_pointer_low_i})
    else $error("last page address wrong");
  table_no_skip_a: assert property (accept && is_table |=> busy_o && !skip_o && !done_o)
    else $error("table read finished too early");
  table_keep_a: assert property (accept && is_table |=> $stable(acc_o) && $stable(flags_o))
    else $error("table read changed accumulator or flags");

endmodule : exec_unit

// file: tb/mcu_skip_sub_swap_table_xor_exec_test.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module mcu_skip_sub_swap_table_xor_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals and model state
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic issue_i = 1'b0;
  logic rom_load_i = 1'b0;
  logic [4:0] op_i = 5'h00;
  logic [7:0] operand_i = 8'h00;
  logic [7:0] imm_i = 8'h00;
  logic [2:0] bit_sel_i = 3'h0;
  logic [7:0] ptr_lo = 8'h00;
  logic [7:0] ptr_hi = 8'h00;
  logic [11:0] rom_addr_i = 12'h000;
  logic [15:0] rom_data_i = 16'h0000;
  logic [7:0] acc_o, mem_wdata_o, latch_o;
  logic [3:0] flags_o;
  logic mem_we_o, busy_o, skip_o, done_o;
  logic [7:0] acc_m = 8'h00;
  logic [7:0] latch_m = 8'h00;
  logic [3:0] fl_m = 4'h0;
  int failures = 0;
  int total_checks = 0;

  exec_unit i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i),
    .operand_i(operand_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i), .program_pointer_low_i(ptr_lo),
    .program_pointer_high_i(ptr_hi), .rom_load_i(rom_load_i), .rom_addr_i(rom_addr_i),
    .rom_data_i(rom_data_i), .acc_o(acc_o), .flags_o(flags_o), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .program_word_high_latch_o(latch_o), .busy_o(busy_o),
    .skip_o(skip_o), .done_o(done_o));

  always #5 clock_i = ~clock_i;

  // ==========================================
  // Closing and watchdog
  task end_of_test;
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end

  // ==========================================
  // One instruction: model, drive, compare
  task run(input logic [4:0] op, input logic [7:0] m, input logic [7:0] x, input logic [2:0] b,
           input logic [7:0] pl, input logic [7:0] ph);
    logic [7:0] a, s, r, wd;
    logic we, sk, tb;
    logic [11:0] ad;
    logic [15:0] w;
    begin
      a = acc_m;
      s = (op == exec_pkg::OP_SUB_IMM || op == exec_pkg::OP_XOR_IMM) ? x : m;
      we = 1'b0;
      sk = 1'b0;
      tb = 1'b0;
      wd = 8'h00;
      ad = (op == exec_pkg::OP_TABLE_READ) ? {ph[3:0], pl} : {4'hF, pl};
      case (op)
        exec_pkg::OP_INC_ACC_SKIP: begin acc_m = m + 8'h01; sk = (acc_m == 8'h00); end
        exec_pkg::OP_SKIP_BIT_SET: sk = m[b];
        exec_pkg::OP_SKIP_BIT_CLR: sk = !m[b];
        exec_pkg::OP_SKIP_ZERO: sk = (m == 8'h00);
        exec_pkg::OP_COPY_SKIP: begin acc_m = m; sk = (m == 8'h00); end
        exec_pkg::OP_SWAP_ACC: acc_m = {m[3:0], m[7:4]};
        exec_pkg::OP_SWAP_MEM: begin we = 1'b1; wd = {m[3:0], m[7:4]}; end
        exec_pkg::OP_SUB_ACC, exec_pkg::OP_SUB_MEM, exec_pkg::OP_SUB_IMM:
        begin
          r = a - s;
          fl_m[exec_pkg::FLAG_C] = (a >= s);
          fl_m[exec_pkg::FLAG_AC] = (a[3:0] >= s[3:0]);
          fl_m[exec_pkg::FLAG_Z] = (r == 8'h00);
          fl_m[exec_pkg::FLAG_OV] = (a[7] != s[7]) && (r[7] != a[7]);
          if (op == exec_pkg::OP_SUB_MEM) begin we = 1'b1; wd = r; end else acc_m = r;
        end
        exec_pkg::OP_XOR_ACC, exec_pkg::OP_XOR_MEM, exec_pkg::OP_XOR_IMM:
        begin
          r = a ^ s;
          fl_m[exec_pkg::FLAG_Z] = (r == 8'h00);
          if (op == exec_pkg::OP_XOR_MEM) begin we = 1'b1; wd = r; end else acc_m = r;
        end
        default:
        begin
          tb = 1'b1;
          we = 1'b1;
          w = 16'($urandom);
          wd = w[7:0];
          latch_m = w[15:8];
          rom_load_i = 1'b1;
          rom_addr_i = ad;
          rom_data_i = w;
          @(negedge clock_i);
          rom_load_i = 1'b0;
        end
      endcase
      op_i = op;
      operand_i = m;
      imm_i = x;
      bit_sel_i = b;
      ptr_lo = pl;
      ptr_hi = ph;
      issue_i = 1'b1;
      @(negedge clock_i);
      if (sk || tb)
      begin
        `CHK(skip_o, sk)
        `CHK({busy_o, done_o}, 2'b10)
        // Keep offering while busy: the new instruction must be dropped
        op_i = exec_pkg::OP_XOR_IMM;
        imm_i = 8'hFF;
        @(negedge clock_i);
      end
      issue_i = 1'b0;
      `CHK({busy_o, done_o, skip_o}, 3'b010)
      `CHK(acc_o, acc_m)
      `CHK(flags_o, fl_m)
      `CHK(mem_we_o, we)
      if (we)
        `CHK(mem_wdata_o, wd)
      `CHK(latch_o, latch_m)
      // Idle cycle so the next request never re-raises a strobe in the same step
      @(negedge clock_i);
    end
  endtask : run

  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(54));
    repeat (6) @(negedge clock_i);
    nrst_i = 1'b1;
    `CHK({acc_o, flags_o, latch_o, busy_o, done_o}, 22'h000000)
    // Corner cases: zero sums, sign boundaries, pointer truncation
    run(exec_pkg::OP_INC_ACC_SKIP, 8'hFF, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_INC_ACC_SKIP, 8'h7F, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SKIP_BIT_SET, 8'h80, 8'h00, 3'h7, 8'h00, 8'h00);
    run(exec_pkg::OP_SKIP_BIT_SET, 8'h7F, 8'h00, 3'h7, 8'h00, 8'h00);
    run(exec_pkg::OP_SKIP_BIT_CLR, 8'hFE, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SKIP_BIT_CLR, 8'h01, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SKIP_ZERO, 8'h00, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SKIP_ZERO, 8'h01, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_COPY_SKIP, 8'h00, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_COPY_SKIP, 8'h80, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SUB_IMM, 8'h00, 8'h01, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SUB_ACC, 8'h7F, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_SUB_MEM, 8'h01, 8'h00, 3'h0, 8'h00, 8'h00);
    run(exec_pkg::OP_TABLE_READ, 8'h00, 8'h00, 3'h0, 8'h12, 8'hFF);
    run(exec_pkg::OP_LAST_PAGE_READ, 8'h00, 8'h00, 3'h0, 8'h34, 8'h00);
    run(exec_pkg::OP_XOR_ACC, 8'h00, 8'h00, 3'h0, 8'h00, 8'h00);
    // Random mix over every opcode but OP_NONE
    repeat (400)
      run(5'(1 + $urandom % 15), 8'($urandom), 8'($urandom), 3'($urandom), 8'($urandom), 8'($urandom));
    end_of_test();
  end
endmodule : mcu_skip_sub_swap_table_xor_exec_test
